// file: hdl/lsc_pkg.sv
// constants and types for the light screen receiver output control
//
// Functional notes
// R1 - trip mode: power up into run, no reset
// R2 - latch mode: hold off run until manual reset
// R3 - self-test fault: stop, outputs off, show diagnostics
// R4 - tests pass: enter alignment, seek sync pattern
// R5 - trip: aligned and synced enters run scanning
// R6 - latch: all aligned, reset lamp double-flashes
// R7 - latch: run only after valid manual reset
// R8 - trip: blocked beam off, clear restores automatically
// R9 - latch: clear after block, zones green, single-flash
// R10 - latch: outputs back on only reset while clear
// R11 - runtime fault: stop, outputs off, error code
// R12 - beam one blocked: zones two-eight off
// R13 - run clear status green, flashing if reduced
// R14 - beam one clear in align/latched: show count
// R15 - short invert press flips display; long ignored
// R16 - cascade stop brackets display with goalposts
// R17 - cascade stop: outputs off, red, reset lamp on
// R18 - operator holds reset quarter to two seconds
// R19 - lockout left only by manual reset, fault gone
// R20 - outputs off in every state except run clear
package lsc_pkg;
	localparam logic [3:0] ADDR_CTRL = 4'h0; // config, read/write
	localparam logic [3:0] ADDR_STATUS = 4'h4; // state and outputs
	localparam logic [3:0] ADDR_COUNT = 4'h8; // blocked beam count
	localparam logic [3:0] ADDR_FAULT = 4'hc; // latched error code
	localparam int CTRL_LATCH_BIT = 0; // 1 = latch outputs, 0 = trip
	localparam int CTRL_REDRES_BIT = 1; // reduced resolution enabled
	localparam logic [1:0] CTRL_RESET_VAL = 2'h0;
	localparam int STAT_OUT_BIT = 4; // safety pair on
	localparam int STAT_INV_BIT = 5; // display inverted
	localparam int STAT_CSTOP_BIT = 6; // cascade stop seen
	localparam int CLK_KHZ = 125000; // 125 MHz
	localparam int RST_MIN_MS = 250; // shortest valid reset hold
	localparam int RST_MAX_MS = 2000; // longest valid reset hold
	localparam int INV_MAX_MS = 500; // longest invert press honoured
	localparam int FLASH_MS = 250; // indicator flash step
	localparam int RST_MIN_CYC = CLK_KHZ * RST_MIN_MS;
	localparam int RST_MAX_CYC = CLK_KHZ * RST_MAX_MS;
	localparam int INV_MAX_CYC = CLK_KHZ * INV_MAX_MS;
	localparam int FLASH_CYC = CLK_KHZ * FLASH_MS;
	typedef enum logic [2:0] {
		DISP_BLANK, DISP_COUNT, DISP_ERROR, DISP_BEAM1, DISP_CONFIG
	} lsc_disp_type;
	typedef enum logic [3:0] {
		ST_SELFTEST, ST_ALIGN, ST_WAIT_RESET, ST_RUN_CLEAR,
		ST_RUN_BLOCKED, ST_LATCHED, ST_LATCH_CLEAR, ST_LOCKOUT
	} lsc_state_type;
endpackage : lsc_pkg

// file: hdl/lsc_output_control.sv
// receiver control state machine, safety outputs and indicators
`timescale 1ns/100ps
`default_nettype none
module lsc_output_control import lsc_pkg::*; #(
	parameter int BEAMS = 16, // beams per screen, multiple of eight
	parameter int RST_MIN = RST_MIN_CYC,
	parameter int RST_MAX = RST_MAX_CYC,
	parameter int INV_MAX = INV_MAX_CYC,
	parameter int FLASH = FLASH_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic self_test_done,
	input wire logic self_test_fail,
	input wire logic critical_fault,
	input wire logic [7:0] fault_code,
	input wire logic sync_ok,
	input wire logic [BEAMS-1:0] beam_blocked,
	input wire logic reset_switch,
	input wire logic invert_button,
	input wire logic cascade_stop_input,
	output logic [1:0] safety_output_pair,
	output logic reset_led,
	output logic status_red,
	output logic status_green,
	output logic [7:0] zone_red,
	output logic [7:0] zone_green,
	output logic [2:0] disp_mode,
	output logic [7:0] disp_value,
	output logic disp_invert,
	output logic disp_goalposts
);
	localparam int ZW = BEAMS / 8; // beams per zone indicator

	logic rst_s1_q, rst_n_q; // released copy of the reset
	lsc_state_type state_q, state_d;
	logic [1:0] ctrl_q; // latch and reduced-resolution config
	logic [7:0] fault_q; // error code kept for display
	logic [31:0] rst_cnt_q; // reset switch hold time
	logic rst_prev_q;
	logic reset_ok; // one-cycle valid manual reset
	logic [31:0] inv_cnt_q; // invert button hold time
	logic inv_prev_q;
	logic inv_q;
	logic [31:0] fl_cnt_q; // flash step timer
	logic [2:0] fl_ph_q; // flash phase
	logic [7:0] zone_blk;
	logic [7:0] blk_cnt;
	logic any_blk, beam1_blk, fault_now;
	logic single_fl, double_fl, blink;
	logic out_on_d, rled_d, sred_d, sgrn_d;
	logic [7:0] zred_d, zgrn_d;
	lsc_disp_type dmode_d;

	// two-stage release of the asynchronous reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// per-zone blocked flags, each zone covers one eighth of the beams
	genvar z;
	generate
		for (z = 0; z < 8; z++) begin : g_zone
			assign zone_blk[z] = |beam_blocked[z*ZW +: ZW];
		end
	endgenerate

	// total blocked beams for the numeric display
	always_comb begin
		blk_cnt = 8'h00;
		for (int i = 0; i < BEAMS; i++) begin
			blk_cnt = blk_cnt + {7'h00, beam_blocked[i]};
		end
	end

	assign any_blk = |beam_blocked;
	assign beam1_blk = beam_blocked[0];
	assign fault_now = critical_fault | self_test_fail;

	// software config register; writes steer trip/latch and flashing
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q <= CTRL_RESET_VAL;
		end else if (reg_wr && reg_addr == ADDR_CTRL) begin
			ctrl_q <= reg_wdata[1:0];
		end
	end

	// read data, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_CTRL: reg_rdata <= {30'h0, ctrl_q};
				ADDR_STATUS: reg_rdata <= {25'h0, cascade_stop_input, inv_q,
					safety_output_pair[0], state_q};
				ADDR_COUNT: reg_rdata <= {24'h0, blk_cnt};
				ADDR_FAULT: reg_rdata <= {24'h0, fault_q};
				default: reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end

	// reset switch qualifier: valid only if released after a hold in range
	// the counter saturates so an over-long hold stays over-long
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rst_cnt_q <= 32'h0;
			rst_prev_q <= 1'b0;
			reset_ok <= 1'b0;
		end else begin
			rst_prev_q <= reset_switch;
			reset_ok <= 1'b0;
			if (reset_switch) begin
				if (rst_cnt_q != 32'hffffffff) rst_cnt_q <= rst_cnt_q + 32'h1;
			end else begin
				rst_cnt_q <= 32'h0;
				// too short or too long holds are simply dropped [R18]
				if (rst_prev_q && rst_cnt_q >= 32'(RST_MIN) &&
					rst_cnt_q <= 32'(RST_MAX)) reset_ok <= 1'b1;
			end
		end
	end

	// invert button: toggle on release of a short press only
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			inv_cnt_q <= 32'h0;
			inv_prev_q <= 1'b0;
			inv_q <= 1'b0;
		end else begin
			inv_prev_q <= invert_button;
			if (invert_button) begin
				if (inv_cnt_q != 32'hffffffff) inv_cnt_q <= inv_cnt_q + 32'h1;
			end else begin
				inv_cnt_q <= 32'h0;
				if (inv_prev_q && inv_cnt_q <= 32'(INV_MAX)) inv_q <= ~inv_q; // [R15]
			end
		end
	end

	// flash timebase: eight steps give single, double and plain blink
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			fl_cnt_q <= 32'h0;
			fl_ph_q <= 3'h0;
		end else if (fl_cnt_q >= 32'(FLASH - 1)) begin
			fl_cnt_q <= 32'h0;
			fl_ph_q <= fl_ph_q + 3'h1;
		end else begin
			fl_cnt_q <= fl_cnt_q + 32'h1;
		end
	end

	assign single_fl = (fl_ph_q == 3'h0);
	assign double_fl = (fl_ph_q == 3'h0) || (fl_ph_q == 3'h2);
	assign blink = fl_ph_q[0];

	// error code captured when the fault is seen
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			fault_q <= 8'h00;
		end else if (fault_now && state_q != ST_LOCKOUT) begin
			fault_q <= fault_code;
		end
	end

	// operating state; a fault wins over every other event
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_SELFTEST: begin
				if (self_test_done) state_d = ST_ALIGN; // [R4]
			end
			ST_ALIGN: begin
				if (sync_ok && !any_blk) begin
					// latch waits for a reset, trip goes straight to run
					if (ctrl_q[CTRL_LATCH_BIT]) state_d = ST_WAIT_RESET; // [R2] [R6]
					else state_d = ST_RUN_CLEAR; // [R1] [R5]
				end
			end
			ST_WAIT_RESET: begin
				if (!sync_ok || any_blk) state_d = ST_ALIGN;
				else if (reset_ok) state_d = ST_RUN_CLEAR; // [R7]
			end
			ST_RUN_CLEAR: begin
				if (any_blk || !sync_ok) begin
					if (ctrl_q[CTRL_LATCH_BIT]) state_d = ST_LATCHED; // [R9]
					else state_d = ST_RUN_BLOCKED; // [R8]
				end
			end
			ST_RUN_BLOCKED: begin
				if (!any_blk && sync_ok) state_d = ST_RUN_CLEAR; // [R8]
			end
			ST_LATCHED: begin
				if (!any_blk && sync_ok) state_d = ST_LATCH_CLEAR; // [R9]
			end
			ST_LATCH_CLEAR: begin
				if (any_blk || !sync_ok) state_d = ST_LATCHED;
				else if (reset_ok) state_d = ST_RUN_CLEAR; // [R10]
			end
			ST_LOCKOUT: begin
				// only a qualified reset with the fault gone leaves lockout
				if (reset_ok && !fault_now) state_d = ST_ALIGN; // [R19]
			end
			default: state_d = ST_LOCKOUT;
		endcase
		if (fault_now) state_d = ST_LOCKOUT; // [R3] [R11]
	end

	// state register
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) state_q <= ST_SELFTEST;
		else state_q <= state_d;
	end

	// indicator and output decode from the next state
	always_comb begin
		out_on_d = 1'b0;
		rled_d = 1'b1;
		sred_d = 1'b1;
		sgrn_d = 1'b0;
		zred_d = zone_blk;
		zgrn_d = ~zone_blk;
		dmode_d = DISP_COUNT;
		case (state_d)
			ST_SELFTEST: begin
				rled_d = 1'b0;
				sred_d = single_fl;
				zred_d = {8{single_fl}};
				zgrn_d = 8'h00;
				dmode_d = DISP_CONFIG;
			end
			ST_ALIGN: begin
				// beam one dark: no sync, so lamp and status stay off
				rled_d = !beam1_blk;
				sred_d = !beam1_blk;
			end
			ST_WAIT_RESET: begin
				rled_d = double_fl; // [R6]
				dmode_d = DISP_BLANK;
			end
			ST_RUN_CLEAR: begin
				// cascade stop drops the pair and shows red [R17]
				out_on_d = !cascade_stop_input && !any_blk && sync_ok; // [R8]
				sred_d = cascade_stop_input;
				sgrn_d = !cascade_stop_input &&
					(ctrl_q[CTRL_REDRES_BIT] ? blink : 1'b1); // [R13]
				dmode_d = cascade_stop_input ? DISP_BLANK : DISP_CONFIG;
			end
			ST_RUN_BLOCKED, ST_LATCHED: begin
				dmode_d = DISP_COUNT; // [R14]
			end
			ST_LATCH_CLEAR: begin
				rled_d = single_fl; // [R9]
				zred_d = 8'h00;
				zgrn_d = 8'hff; // [R9]
				dmode_d = DISP_BLANK;
			end
			ST_LOCKOUT: begin
				rled_d = 1'b0;
				sred_d = blink;
				zred_d = 8'h00;
				zgrn_d = 8'h00;
				dmode_d = DISP_ERROR; // [R3] [R11]
			end
			default: begin
				rled_d = 1'b0;
			end
		endcase
		// beam one carries sync, so zones two to eight go dark [R12]
		if (beam1_blk && state_d != ST_SELFTEST && state_d != ST_LOCKOUT) begin
			zred_d = 8'h01;
			zgrn_d = 8'h00;
			if (dmode_d == DISP_COUNT) dmode_d = DISP_BEAM1;
		end
	end

	// registered outputs; the pair is on only in run clear [R20]
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			safety_output_pair <= 2'b00;
			reset_led <= 1'b0;
			status_red <= 1'b0;
			status_green <= 1'b0;
			zone_red <= 8'h00;
			zone_green <= 8'h00;
			disp_mode <= 3'h0;
			disp_value <= 8'h00;
			disp_invert <= 1'b0;
			disp_goalposts <= 1'b0;
		end else begin
			safety_output_pair <= {2{out_on_d}}; // [R20]
			reset_led <= rled_d;
			status_red <= sred_d;
			status_green <= sgrn_d;
			zone_red <= zred_d;
			zone_green <= zgrn_d;
			disp_mode <= dmode_d;
			disp_value <= (dmode_d == DISP_ERROR) ? fault_q : blk_cnt; // [R14]
			disp_invert <= inv_q;
			disp_goalposts <= cascade_stop_input; // [R16]
		end
	end
endmodule : lsc_output_control
`default_nettype wire

// file: test/lsc_output_control_chk.sv
// checker bound to the receiver output control ports
`timescale 1ns/100ps
`default_nettype none
module lsc_output_control_chk #(
	parameter int BEAMS = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic self_test_fail,
	input wire logic critical_fault,
	input wire logic [BEAMS-1:0] beam_blocked,
	input wire logic invert_button,
	input wire logic cascade_stop_input,
	input wire logic [1:0] safety_output_pair,
	input wire logic reset_led,
	input wire logic status_red,
	input wire logic [7:0] zone_green,
	input wire logic disp_invert,
	input wire logic disp_goalposts
);
	// one domain; checks sleep while reset is low
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_pair_same:
		assert property (safety_output_pair[0] == safety_output_pair[1])
		else $error("pair bits split");
	a_block_off:
		assert property (|beam_blocked |=> safety_output_pair == 2'h0)
		else $error("outputs on with a beam blocked");
	a_fault_off:
		assert property (critical_fault |=> safety_output_pair == 2'h0)
		else $error("outputs on after fault");
	a_test_fail_off:
		assert property (self_test_fail |=> safety_output_pair == 2'h0)
		else $error("outputs on after self-test fault");
	a_cstop_off:
		assert property (cascade_stop_input && safety_output_pair[0] && !critical_fault
			|=> safety_output_pair == 2'h0 && status_red && reset_led)
		else $error("cascade stop not honoured");
	a_goalpost_lag:
		assert property (disp_goalposts == $past(cascade_stop_input))
		else $error("goalposts do not follow cascade stop");
	a_beam1_zones:
		assert property (beam_blocked[0] |=> zone_green[7:1] == 7'h0)
		else $error("zones lit with beam one blocked");
	a_on_lamps:
		assert property (safety_output_pair[0] |-> !status_red && reset_led)
		else $error("lamps wrong while outputs on");
	// a flip may land one or two edges after the release
	a_invert_rel:
		assert property ($changed(disp_invert) |-> !$past(invert_button)
			&& ($past(invert_button, 2) || $past(invert_button, 3)))
		else $error("display flipped without a press");
endmodule : lsc_output_control_chk
bind lsc_output_control lsc_output_control_chk #(.BEAMS(BEAMS)) i_lsc_output_control_chk (
	.clk, .rst_b, .self_test_fail, .critical_fault, .beam_blocked, .invert_button,
	.cascade_stop_input, .safety_output_pair, .reset_led, .status_red, .zone_green,
	.disp_invert, .disp_goalposts
);
`default_nettype wire

// file: test/lsc_emitter_model.sv
// emitter and beam field model facing the receiver optics
`timescale 1ns/100ps
`default_nettype none
module lsc_emitter_model #(
	parameter int BEAMS = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic aim, // emitter pointed at the receiver
	input wire logic [3:0] lag, // cycles before sync is found
	input wire logic [BEAMS-1:0] blk, // objects in the field
	output logic sync_ok,
	output logic [BEAMS-1:0] beam_blocked
);
	logic [3:0] cnt_q; // cycles of aim so far
	// the sync pattern is seen only after lag cycles of aim
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) cnt_q <= 4'h0;
		else if (!aim) cnt_q <= 4'h0;
		else if (cnt_q != lag) cnt_q <= cnt_q + 4'h1;
	end
	assign sync_ok = aim && (cnt_q == lag);
	// no sync means no beam can be read, so all look blocked
	assign beam_blocked = sync_ok ? blk : '1;
endmodule : lsc_emitter_model
`default_nettype wire

// file: test/lsc_output_control_tb.sv
// self-checking bench for the receiver output control
`timescale 1ns/100ps
`default_nettype none
module lsc_output_control_tb import lsc_pkg::*; ;
	// bench inputs, all defined from time zero
	logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d1 = 1'b0;
	logic st_done = 1'b0, st_fail = 1'b0, crit = 1'b0, rsw = 1'b0, inv = 1'b0;
	logic cstop = 1'b0, aim = 1'b0, sync_ok;
	logic [3:0] reg_addr = 4'h0, lag = 4'h0;
	logic [7:0] fcode = 8'h0;
	logic [15:0] blk = 16'h0, beam_blocked;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'h22c0;
	logic [31:0] exp_q[$]; // expected read data, oldest first
	logic [1:0] pair; // safety pair as seen by the machine
	logic s_grn, r_led; // status green and reset lamp
	logic [2:0] d_mode; // display mode
	logic [7:0] z_red, d_val; // zone red lamps and display value
	int k; // flags of lamp levels seen in a window
	int n_errors = 0, n_tests = 0;
	initial forever #4 clk = ~clk;
	// short counts keep the run brief
	lsc_output_control #(.RST_MIN(4), .RST_MAX(20), .INV_MAX(10), .FLASH(2)) i_lsc_output_control (
		.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.self_test_done(st_done), .self_test_fail(st_fail), .critical_fault(crit),
		.fault_code(fcode), .sync_ok, .beam_blocked, .reset_switch(rsw),
		.invert_button(inv), .cascade_stop_input(cstop), .safety_output_pair(pair),
		.reset_led(r_led), .status_red(), .status_green(s_grn), .zone_red(z_red),
		.zone_green(), .disp_mode(d_mode), .disp_value(d_val), .disp_invert(),
		.disp_goalposts());
	lsc_emitter_model i_lsc_emitter_model (.clk, .rst_b, .aim, .lag, .blk, .sync_ok,
		.beam_blocked);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// a read leaves its note for the watcher
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask : rd
	// status is {cascade, inverted, outputs, state}
	task automatic sts(input logic [6:0] v);
		cyc(3);
		rd(ADDR_STATUS, {25'h0, v});
	endtask : sts
	// operator holds the reset switch for n cycles
	task automatic rsw_hold(input int n);
		@(posedge clk);
		rsw <= 1'b1;
		cyc(n);
		rsw <= 1'b0;
		cyc(2);
	endtask : rsw_hold
	task automatic press(input int n);
		@(posedge clk);
		inv <= 1'b1;
		cyc(n);
		inv <= 1'b0;
	endtask : press
	task automatic wait_sync;
		for (int i = 0; i < 40 && sync_ok !== 1'b1; i++) @(posedge clk);
		if (sync_ok !== 1'b1) begin
			n_errors++;
			print_verdict();
		end
	endtask : wait_sync
	task automatic cmp(input logic [31:0] got, input logic [31:0] e);
		n_tests++;
		if (got !== e) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, e);
		end
	endtask : cmp
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict
	// read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		rd_d1 <= reg_rd;
		if (rd_d1) cmp(reg_rdata, exp_q.pop_front());
	end
	// a hang ends in the same report
	initial begin
		cyc(20000);
		n_errors++;
		print_verdict();
	end
	initial begin
		cyc(10);
		rst_b <= 1'b1;
		cyc(3);
		wr(4'h8, 32'hff);
		rd(4'h2, 32'h0);
		rd(ADDR_CTRL, 32'h0);
		sts(7'h00);
		st_done <= 1'b1;
		sts(7'h01);
		aim <= 1'b1;
		wait_sync();
		sts(7'h13);
		seed = lfsr(seed);
		blk <= seed[15:0] | 16'h1;
		sts(7'h04);
		rd(ADDR_COUNT, 32'($countones(seed[15:0] | 16'h1)));
		// outputs are settled away from the launching edge
		@(negedge clk);
		cmp({29'h0, d_mode}, {29'h0, DISP_BEAM1});
		cmp({24'h0, z_red}, 32'h1);
		cmp({24'h0, d_val}, 32'($countones(seed[15:0] | 16'h1)));
		@(posedge clk);
		blk <= 16'h0;
		sts(7'h13);
		seed = lfsr(seed);
		fcode <= seed[7:0];
		crit <= 1'b1;
		sts(7'h07);
		rd(ADDR_FAULT, {24'h0, seed[7:0]});
		@(negedge clk);
		cmp({29'h0, d_mode}, {29'h0, DISP_ERROR});
		cmp({24'h0, d_val}, {24'h0, seed[7:0]});
		cmp({31'h0, r_led}, 32'h0);
		@(posedge clk);
		crit <= 1'b0;
		rsw_hold(6);
		sts(7'h13);
		wr(ADDR_CTRL, 32'h1);
		aim <= 1'b0;
		sts(7'h05);
		crit <= 1'b1;
		cyc(2);
		crit <= 1'b0;
		rsw_hold(6);
		sts(7'h01);
		lag <= 4'h9;
		aim <= 1'b1;
		wait_sync();
		sts(7'h02);
		// waiting for reset: the lamp must both light and go dark
		k = 0;
		for (int i = 0; i < 20; i++) begin
			@(negedge clk);
			if (r_led === 1'b0) k = k | 1;
			if (r_led === 1'b1) k = k | 2;
		end
		@(posedge clk);
		cmp(32'(k), 32'h3);
		rsw_hold(2);
		sts(7'h02);
		rsw_hold(6);
		sts(7'h13);
		blk <= 16'h0100;
		sts(7'h05);
		blk <= 16'h0;
		sts(7'h06);
		@(negedge clk);
		cmp({24'h0, z_red}, 32'h0);
		@(posedge clk);
		rsw_hold(25);
		sts(7'h06);
		rsw_hold(6);
		sts(7'h13);
		cstop <= 1'b1;
		sts(7'h43);
		cstop <= 1'b0;
		sts(7'h13);
		press(3);
		sts(7'h33);
		press(15);
		sts(7'h33);
		wr(ADDR_CTRL, 32'h3);
		rd(ADDR_CTRL, 32'h3);
		// reduced resolution: green flashes while the pair stays on
		k = 0;
		for (int i = 0; i < 20; i++) begin
			@(negedge clk);
			if (pair === 2'b11 && s_grn === 1'b0) k = k | 1;
			if (pair === 2'b11 && s_grn === 1'b1) k = k | 2;
		end
		@(posedge clk);
		cmp(32'(k), 32'h3);
		// second reset mid-run, with a failing self-test
		rst_b <= 1'b0;
		st_done <= 1'b0;
		st_fail <= 1'b1;
		cyc(3);
		rst_b <= 1'b1;
		sts(7'h07);
		cyc(3);
		print_verdict();
	end
endmodule : lsc_output_control_tb
`default_nettype wire
